// [verilog/i2c_slave_interface.sv]
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_interface_map.svh"

// Overview of operation
// - Data and clock pins open-drain only
// - Selected by address, no chip select
// - Slave only: transmit and receive modes
// - Software avoids halt during transfers
// - Enabled pins open-collector, pull-up kept
// - All data bytes pass through data buffer
// - Debounce select: none, two, four clocks
// - Enable bit routes pins to bus
// - Control unused bits read zero
// - Pins not assigned: interface off, idle
// - Status bit layout, flags hcf to rxak
// - Address register bits seven to one
// - Timeout: enable, flag, period select
// - Byte flag clears on start or data read, sets done
// - Busy set on start, cleared stop
// - Transmit ack bit driven ninth clock
// - Address match sets flag, interrupt
module i2c_slave_interface
    import i2c_slave_interface_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    input  wire logic       pin_select_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            scl_oe_n_o,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    output logic            pull_up_en_o,
    output logic            irq_o
);

    // *************************************************************
    // Registers
    // *************************************************************
    byte_t        ctrl_reg;
    byte_t        data_reg;
    byte_t        own_addr_reg;
    logic         toc_en_reg;
    logic         toc_flag_reg;
    logic [5:0]   toc_sel_reg;
    logic         hcf_reg;
    logic         haas_reg;
    logic         hbb_reg;
    logic         htx_reg;
    logic         txak_reg;
    logic         srw_reg;
    logic         rnic_reg;
    logic         rxak_reg;
    logic [3:0]   irq_stat_reg;
    logic [3:0]   irq_en_reg;
    logic [2:0]   scl_sync_reg;
    logic [2:0]   sda_sync_reg;
    logic         scl_f_reg;
    logic         sda_f_reg;
    logic         scl_prev_reg;
    logic         sda_prev_reg;
    logic [2:0]   scl_cnt_reg;
    logic [2:0]   sda_cnt_reg;
    link_state_e  state_reg;
    logic [2:0]   bit_cnt_reg;
    byte_t        shift_reg;
    logic         sda_drv_reg;
    logic [21:0]  tout_cnt_reg;
    logic         buf_read_reg;
    logic         addr_armed_reg;

    logic active;
    logic [2:0] dbnc_len;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic addr_match;
    logic tout_hit;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [3:0] irq_en_next;

    // Pins only work for the bus when both selections agree
    // enable routes pins
    assign active   = ctrl_reg[`CTRL_ENABLE_BIT] & pin_select_i;

    // Debounce length decode; codes 10 and 11 both mean four clocks
    // debounce select decode
    function automatic logic [2:0] dbnc_cycles(input logic [1:0] sel);
        case (sel)
            2'b00:   dbnc_cycles = 3'h0;
            2'b01:   dbnc_cycles = `DBNC_SHORT_CYC;
            default: dbnc_cycles = `DBNC_LONG_CYC;
        endcase
    endfunction
    assign dbnc_len = dbnc_cycles(ctrl_reg[`CTRL_DBNC_HI:`CTRL_DBNC_LO]);

    // *************************************************************
    // Pin sampling: three flops, change taken when 2nd and 3rd agree
    // *************************************************************
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
        end
    end

    // Filtered level moves only after the count of stable samples
    // stable sample filter
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_f_reg   <= 1'b1;
            sda_f_reg   <= 1'b1;
            scl_cnt_reg <= 3'h0;
            sda_cnt_reg <= 3'h0;
        end else begin
            if (scl_sync_reg[2] != scl_sync_reg[1] ||
                scl_sync_reg[2] == scl_f_reg) begin
                scl_cnt_reg <= 3'h0;
            end else if (scl_cnt_reg >= dbnc_len) begin
                scl_f_reg   <= scl_sync_reg[2];
                scl_cnt_reg <= 3'h0;
            end else begin
                scl_cnt_reg <= scl_cnt_reg + 3'h1;
            end
            if (sda_sync_reg[2] != sda_sync_reg[1] ||
                sda_sync_reg[2] == sda_f_reg) begin
                sda_cnt_reg <= 3'h0;
            end else if (sda_cnt_reg >= dbnc_len) begin
                sda_f_reg   <= sda_sync_reg[2];
                sda_cnt_reg <= 3'h0;
            end else begin
                sda_cnt_reg <= sda_cnt_reg + 3'h1;
            end
        end
    end

    // Edge history of the filtered lines
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_f_reg;
            sda_prev_reg <= sda_f_reg;
        end
    end

    assign scl_rise  = active & scl_f_reg & ~scl_prev_reg;
    assign scl_fall  = active & ~scl_f_reg & scl_prev_reg;
    assign start_det = active & scl_f_reg & scl_prev_reg &
                       sda_prev_reg & ~sda_f_reg;
    assign stop_det  = active & scl_f_reg & scl_prev_reg &
                       ~sda_prev_reg & sda_f_reg;
    assign byte_done = scl_fall & (bit_cnt_reg == 3'h0) &
                       (state_reg == ST_RX || state_reg == ST_TX);
    assign addr_match = (shift_reg[7:1] == own_addr_reg[7:1]);

    // *************************************************************
    // Bus state machine
    // *************************************************************
    // Slave only: SCL is never driven, SDA only pulled low
    // slave transfer modes
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 3'h7;
            shift_reg   <= 8'h00;
            sda_drv_reg <= 1'b0;
            addr_armed_reg <= 1'b0;
        end else if (!active || stop_det || tout_hit) begin
            state_reg   <= ST_IDLE;
            sda_drv_reg <= 1'b0;
        end else if (start_det) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 3'h7;
            sda_drv_reg <= 1'b0;
            addr_armed_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sda_drv_reg <= 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_f_reg};
                        addr_armed_reg <= 1'b1;
                    end
                    // The clock fall that closes a start is no data bit
                    if (scl_fall &&
                        (addr_armed_reg || state_reg == ST_RX)) begin
                        bit_cnt_reg <= bit_cnt_reg - 3'h1;
                        if (bit_cnt_reg == 3'h0) begin
                            if (state_reg == ST_ADDR && !addr_match) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                sda_drv_reg <= (state_reg == ST_ADDR) ?
                                               1'b1 : ~txak_reg;
                                state_reg   <= ST_ACK;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 3'h7;
                        if (htx_reg) begin
                            shift_reg   <= data_reg;
                            sda_drv_reg <= ~data_reg[7];
                            state_reg   <= ST_TX;
                        end else begin
                            sda_drv_reg <= 1'b0;
                            state_reg   <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg - 3'h1;
                        if (bit_cnt_reg == 3'h0) begin
                            sda_drv_reg <= 1'b0;
                            state_reg   <= ST_RACK;
                        end else begin
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            sda_drv_reg <= ~shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    // Master nack releases SDA for its stop; an ack
                    // starts the next byte on this same fall
                    if (scl_fall && rxak_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 3'h7;
                        shift_reg   <= data_reg;
                        sda_drv_reg <= ~data_reg[7];
                        state_reg   <= ST_TX;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin outputs; output enable is active low while pulling SDA
    // open-drain pins
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sda_oe_n_o   <= 1'b1;
            scl_oe_n_o   <= 1'b1;
            sda_o        <= 1'b0;
            scl_o        <= 1'b0;
            pull_up_en_o <= 1'b0;
        end else begin
            sda_oe_n_o   <= ~(sda_drv_reg & active);
            scl_oe_n_o   <= 1'b1;
            sda_o        <= 1'b0;
            scl_o        <= 1'b0;
            pull_up_en_o <= active;
        end
    end

    // *************************************************************
    // Status flags
    // *************************************************************
    // byte flag update
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hcf_reg  <= 1'b1;
            haas_reg <= 1'b0;
            hbb_reg  <= 1'b0;
            srw_reg  <= 1'b1;
            rxak_reg <= 1'b0;
        end else begin
            if (start_det) begin
                hcf_reg <= 1'b0;
            end else if (byte_done || stop_det) begin
                hcf_reg <= 1'b1;
            end else if (buf_read_reg) begin
                hcf_reg <= 1'b0;
            end
            if (start_det) begin
                hbb_reg <= 1'b1;
            end else if (stop_det || !active) begin
                hbb_reg <= 1'b0;
            end
            if (start_det || stop_det) begin
                haas_reg <= 1'b0;
            end else if (state_reg == ST_ADDR && scl_fall &&
                         bit_cnt_reg == 3'h0 && addr_match) begin
                haas_reg <= 1'b1;
                srw_reg  <= shift_reg[0];
            end else if (byte_done) begin
                haas_reg <= 1'b0;
            end
            if (state_reg == ST_RACK && scl_rise) begin
                rxak_reg <= sda_f_reg;
            end
        end
    end

    // Timeout counter: SCL held still while busy for too long
    // timeout function
    assign tout_hit = toc_en_reg & hbb_reg &
                      (tout_cnt_reg[21:10] > {6'h00, toc_sel_reg});
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tout_cnt_reg <= 22'h000000;
        end else if (!hbb_reg || scl_rise || scl_fall || tout_hit) begin
            tout_cnt_reg <= 22'h000000;
        end else begin
            tout_cnt_reg <= tout_cnt_reg + 22'h000001;
        end
    end

    // *************************************************************
    // Register writes
    // *************************************************************
    // unused bits held zero
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg     <= `CTRL_RESET;
            own_addr_reg <= 8'h00;
            toc_en_reg   <= 1'b0;
            toc_sel_reg  <= 6'h00;
            htx_reg      <= 1'b0;
            txak_reg     <= 1'b0;
            rnic_reg     <= 1'b1;
            irq_en_reg   <= 4'h0;
        end else if (wr_i) begin
            case (addr_i)
                `SER_CONTROL_ADDR:
                    ctrl_reg <= wdata_i & `CTRL_WRITE_MASK;
                `SER_ADDRESS_ADDR:
                    own_addr_reg <= wdata_i & `ADDR_WRITE_MASK;
                `SER_STATUS_ADDR: begin
                    htx_reg  <= wdata_i[`STAT_HTX_BIT];
                    txak_reg <= wdata_i[`STAT_TXAK_BIT];
                    rnic_reg <= wdata_i[`STAT_RNIC_BIT];
                end
                `SER_TIMEOUT_ADDR: begin
                    toc_en_reg  <= wdata_i[`TOC_EN_BIT];
                    toc_sel_reg <= wdata_i[5:0];
                end
                `INT_ENABLE_ADDR:
                    irq_en_reg <= wdata_i[3:0];
                default: begin
                end
            endcase
        end
    end

    // Data buffer: software write or a received byte lands here
    // single data buffer
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_reg <= 8'h00;
        end else if (byte_done && state_reg == ST_RX) begin
            data_reg <= shift_reg;
        end else if (wr_i && addr_i == `SER_DATA_ADDR) begin
            data_reg <= wdata_i;
        end
    end

    // Timeout flag: hardware set wins over software clear
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            toc_flag_reg <= 1'b0;
        end else if (tout_hit) begin
            toc_flag_reg <= 1'b1;
        end else if (wr_i && addr_i == `SER_TIMEOUT_ADDR &&
                     !wdata_i[`TOC_FLAG_BIT]) begin
            toc_flag_reg <= 1'b0;
        end
    end

    // *************************************************************
    // Interrupt status, sticky; a set beats a same-cycle clear
    // *************************************************************
    assign irq_set = {tout_hit, stop_det,
                      haas_reg == 1'b0 && state_reg == ST_ADDR &&
                      scl_fall && bit_cnt_reg == 3'h0 && addr_match,
                      byte_done};
    assign irq_clr = (wr_i && addr_i == `INT_CLEAR_ADDR) ?
                     wdata_i[3:0] : 4'h0;
    // Enable as it stands after this edge, so the pin follows it at once
    assign irq_en_next = (wr_i && addr_i == `INT_ENABLE_ADDR) ?
                         wdata_i[3:0] : irq_en_reg;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_reg <= 4'h0;
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
            irq_o        <= |((irq_set | (irq_stat_reg & ~irq_clr))
                              & irq_en_next);
        end
    end

    // *************************************************************
    // Register reads, data one cycle after the strobe
    // *************************************************************
    // status layout
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o      <= 8'h00;
            buf_read_reg <= 1'b0;
        end else begin
            buf_read_reg <= rd_i && addr_i == `SER_DATA_ADDR;
            rdata_o      <= 8'h00;
            if (rd_i) begin
                case (addr_i)
                    `SER_CONTROL_ADDR: rdata_o <= ctrl_reg;
                    `SER_STATUS_ADDR:  rdata_o <= {hcf_reg, haas_reg,
                                          hbb_reg, htx_reg, txak_reg,
                                          srw_reg, rnic_reg, rxak_reg};
                    `SER_DATA_ADDR:    rdata_o <= data_reg;
                    `SER_ADDRESS_ADDR: rdata_o <= own_addr_reg;
                    `SER_TIMEOUT_ADDR: rdata_o <= {toc_en_reg, toc_flag_reg,
                                                   toc_sel_reg};
                    `INT_STATUS_ADDR:  rdata_o <= {4'h0, irq_stat_reg};
                    `INT_ENABLE_ADDR:  rdata_o <= {4'h0, irq_en_reg};
                    default:           rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // *************************************************************
    // Checks
    // *************************************************************
    a_busy_on_start: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        start_det |=> hbb_reg)
        else $error("busy flag not set after start");
    a_busy_on_stop: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        stop_det && !start_det |=> !hbb_reg)
        else $error("busy flag not cleared after stop");
    a_byte_flag_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        byte_done && !start_det |=> hcf_reg)
        else $error("byte flag not set after byte");
    a_ctrl_zero_bits: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl_reg & ~`CTRL_WRITE_MASK) == 8'h00)
        else $error("unused control bits not zero");
    a_scl_never_driven: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        scl_oe_n_o)
        else $error("clock line driven by slave");
    a_sda_off_disabled: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !active |=> sda_oe_n_o)
        else $error("data line driven while disabled");
    a_sda_low_only: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        sda_o == 1'b0)
        else $error("data line driven high");
    a_addr_bit0_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        own_addr_reg[0] == 1'b0)
        else $error("address bit zero set");
    a_irq_follow: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        irq_o == (|(irq_stat_reg & irq_en_reg)))
        else $error("enabled event without interrupt");
    c_addr_match: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(haas_reg));
    c_rx_byte: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        byte_done && state_reg == ST_RX);
    c_tx_byte: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        byte_done && state_reg == ST_TX);
    c_timeout: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        tout_hit);

endmodule
`default_nettype wire

// [verilog/i2c_slave_interface_map.svh]
`ifndef I2C_SLAVE_INTERFACE_MAP_SVH
`define I2C_SLAVE_INTERFACE_MAP_SVH

// *****************************************************************
// Register offsets (byte addresses on the plain register port)
// *****************************************************************
`define SER_CONTROL_ADDR   4'h0
`define SER_STATUS_ADDR    4'h1
`define SER_DATA_ADDR      4'h2
`define SER_ADDRESS_ADDR   4'h3
`define SER_TIMEOUT_ADDR   4'h4
`define INT_STATUS_ADDR    4'h5
`define INT_ENABLE_ADDR    4'h6
`define INT_CLEAR_ADDR     4'h7

// *****************************************************************
// Field positions and reset values
// *****************************************************************
`define CTRL_DBNC_HI       3
`define CTRL_DBNC_LO       2
`define CTRL_ENABLE_BIT    1
`define CTRL_WRITE_MASK    8'h0e
`define CTRL_RESET         8'h00
`define STAT_HCF_BIT       7
`define STAT_HAAS_BIT      6
`define STAT_HBB_BIT       5
`define STAT_HTX_BIT       4
`define STAT_TXAK_BIT      3
`define STAT_SRW_BIT       2
`define STAT_RNIC_BIT      1
`define STAT_RXAK_BIT      0
`define STAT_RESET         8'h86
`define ADDR_WRITE_MASK    8'hfe
`define TOC_EN_BIT         7
`define TOC_FLAG_BIT       6
`define TOC_SEL_MASK       8'h3f
`define TOC_UNIT_CYCLES    16'h0400
`define IRQ_BYTE_BIT       0
`define IRQ_ADDR_BIT       1
`define IRQ_STOP_BIT       2
`define IRQ_TOUT_BIT       3
`define IRQ_WIDTH          4

// *****************************************************************
// Timing counts in system clocks
// *****************************************************************
`define DBNC_SHORT_CYC     3'h2
`define DBNC_LONG_CYC      3'h4

`endif

// [verilog/i2c_slave_interface_pkg.sv]
`default_nettype none
package i2c_slave_interface_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_RX   = 3'b011,
        ST_TX   = 3'b100,
        ST_RACK = 3'b101
    } link_state_e;
    typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// [tb/i2c_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// *****************************************************************
// Bus master at the far side of the two-wire link
// *****************************************************************
module i2c_master_model (
    input  wire logic mclk_i,
    input  wire logic sda_oe_n_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic sda_drv;
    // wired-and pull-up: released line reads high
    assign sda_o = sda_drv & sda_oe_n_i;
    // Clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_drv = 1'b1;
    end
    // Half bit is 40 system clocks, far above the input filter delay
    task automatic hp;
        repeat (40) @(posedge mclk_i);
    endtask
    // frame opens with data falling while clock high
    task automatic start;
        sda_drv <= 1'b0;
        hp;
        scl_o <= 1'b0;
        hp;
    endtask
    task automatic stop;
        sda_drv <= 1'b0;
        hp;
        scl_o <= 1'b1;
        hp;
        sda_drv <= 1'b1;
        hp;
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_drv <= b;
        hp;
        scl_o <= 1'b1;
        hp;
        r = sda_o;
        scl_o <= 1'b0;
    endtask
    // bytes go out most significant bit first, ninth bit released
    task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                          output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(1'b1, ack);
    endtask
endmodule
`default_nettype wire

// [tb/i2c_slave_interface_test.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_interface_test;
    import i2c_slave_interface_pkg::*;
    logic       mclk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0;
    logic       pin_select_i = 0, ack, scl_line, sda_line;
    logic [3:0] addr_i = 4'h0;
    byte_t      wdata_i = 8'h00, rdata_o, own, d, q, st;
    logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, pull_up_en_o, irq_o;
    int         n_fail = 0, samples_checked = 0, cyc = 0;
    always #2 mclk_i = ~mclk_i;
    i2c_slave_interface u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_select_i(pin_select_i), .scl_i(scl_line),
        .sda_i(sda_line), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .pull_up_en_o(pull_up_en_o), .irq_o(irq_o));
    i2c_master_model u_master (.mclk_i(mclk_i), .sda_oe_n_i(sda_oe_n_o),
        .scl_o(scl_line), .sda_o(sda_line));
    task automatic chk(input byte_t got, input byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input byte_t v);
        @(posedge mclk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output byte_t v);
        @(posedge mclk_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        // Return on an edge so the next driver changes just after it
        @(posedge mclk_i);
    endtask
    task automatic rchk(input logic [3:0] a, input byte_t e);
        byte_t v;
        rd(a, v);
        chk(v, e);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cut a hang short well beyond the expected run length
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        void'($urandom(32'hd2a1));
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rchk(4'h0, 8'h00);
        rchk(4'h1, 8'h86);
        rchk(4'h3, 8'h00);
        rchk(4'h4, 8'h00);
        rchk(4'h8, 8'h00);
        wr(4'h0, 8'hff);
        rchk(4'h0, 8'h0e);
        repeat (3) @(posedge mclk_i);
        chk(8'(pull_up_en_o), 8'h00);
        pin_select_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(8'(pull_up_en_o), 8'h01);
        own = 8'($urandom_range(1, 127));
        wr(4'h3, {own[6:0], 1'b1});
        rchk(4'h3, {own[6:0], 1'b0});
        wr(4'h6, 8'h0f);
        // Every debounce setting carries a full receive transfer
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, {4'h0, m[1:0], 2'b10});
            u_master.start;
            rd(4'h1, st);
            chk(st & 8'h20, 8'h20);
            u_master.byte_x({own[6:0], 1'b0}, q, ack);
            chk(8'(ack), 8'h00);
            rd(4'h5, st);
            chk(st & 8'h02, 8'h02);
            chk(8'(irq_o), 8'h01);
            d = 8'($urandom);
            u_master.byte_x(d, q, ack);
            chk(8'(ack), 8'h00);
            rchk(4'h2, d);
            wr(4'h1, 8'h0a);
            u_master.byte_x(8'($urandom), q, ack);
            chk(8'(ack), 8'h01);
            wr(4'h1, 8'h02);
            u_master.stop;
            rd(4'h1, st);
            chk(st & 8'h20, 8'h00);
        end
        u_master.start;
        u_master.byte_x({~own[6:0], 1'b0}, q, ack);
        chk(8'(ack), 8'h01);
        u_master.stop;
        d = 8'($urandom);
        wr(4'h2, d);
        // No clock stretching: transmit select must be set before the frame
        wr(4'h1, 8'h12);
        u_master.start;
        u_master.byte_x({own[6:0], 1'b1}, q, ack);
        chk(8'(ack), 8'h00);
        rd(4'h1, st);
        chk(st & 8'h04, 8'h04);
        u_master.byte_x(8'hff, q, ack);
        chk(q, d);
        u_master.stop;
        // Clock held low past one timeout unit of 1024 clocks
        wr(4'h4, 8'h80);
        u_master.start;
        repeat (1100) @(posedge mclk_i);
        rchk(4'h4, 8'hc0);
        rd(4'h5, st);
        chk(st & 8'h08, 8'h08);
        wr(4'h4, 8'h80);
        rchk(4'h4, 8'h80);
        u_master.stop;
        wr(4'h4, 8'h00);
        wr(4'h6, 8'h00);
        repeat (2) @(posedge mclk_i);
        chk(8'(irq_o), 8'h00);
        wr(4'h6, 8'h0f);
        repeat (2) @(posedge mclk_i);
        chk(8'(irq_o), 8'h01);
        wr(4'h7, 8'h0f);
        repeat (2) @(posedge mclk_i);
        chk(8'(irq_o), 8'h00);
        chk(8'(scl_oe_n_o), 8'h01);
        end_of_test;
    end
endmodule
`default_nettype wire
